// ==== fscr_pkg.sv ====
// Package of offsets, fields and reset values for the flash security config
package fscr_pkg;
   localparam int          ADDR_W          = 16;
   localparam logic [15:0] SEC_STATUS_ADDR = 16'h0101;
   localparam logic [15:0] CMD_IDX_ADDR    = 16'h0102;
   localparam logic [15:0] RSV_TEST_ADDR   = 16'h0103;
   localparam logic [15:0] CFG_CTRL_ADDR   = 16'h0104;
   // Security status fields
   localparam int          KEY_HI          = 7;
   localparam int          KEY_LO          = 6;
   localparam int          SECST_HI        = 1;
   localparam int          SECST_LO        = 0;
   localparam logic [1:0]  KEY_ENABLED     = 2'h2;
   localparam logic [1:0]  SEC_UNSECURED   = 2'h2;
   localparam logic [7:0]  SEC_ALL_SET     = 8'hff;
   // Command index field
   localparam int          IDX_W           = 3;
   // Configuration fields
   localparam int          CFG_DONE_IE     = 7;
   localparam int          CFG_IGN_SF      = 4;
   localparam int          CFG_FORCE_DF    = 1;
   localparam int          CFG_FORCE_SF    = 0;
   localparam logic [7:0]  CFG_WR_MASK     = 8'h93;
   localparam logic [7:0]  CFG_RESET       = 8'h00;
   localparam logic [2:0]  IDX_RESET       = 3'h0;
   localparam logic [7:0]  SEC_RESET       = 8'hff;
endpackage

// ==== fscr_regs.sv ====
// Flash security, command index, reserved test and configuration registers
// Operation
// - Security status readable, writes ignored
// - Security reset to all ones, loaded from flash byte when LOAD_VALID pulses
// - Double fault at load sets all bits
// - Backdoor key enabled only for code 10
// - Unsecured only when security state is 10
// - Backdoor unlock forces security state to 10
// - Index picks word of command object array
// - Index bits writable, others read zero
// - Reserved test register reads zero, ignores writes
// - Config bits 7,4,1,0 read/write, rest zero
// - Done interrupt when flag and enable set
// - Suppress single fault blocks report and interrupt
// - Force double fault flags every array read
// - Forced double fault leaves capture untouched
// - Force double cleared only by writing zero
// - Force single fault flags every array read unless suppress single fault is set
// - Forced single fault leaves capture untouched
// - Force single cleared only by writing zero
// - Done flag set on finish, low while running
// - Double fault interrupt when flag and enable
// - Single fault interrupt when flag and enable
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module fscr_regs
   import fscr_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              RST_N,
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [7:0]        WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic      [7:0]        RDATA,
   input  wire logic              LOAD_VALID,
   input  wire logic [7:0]        LOAD_BYTE,
   input  wire logic              LOAD_DBL_FAULT,
   input  wire logic              BACKDOOR_UNLOCK,
   input  wire logic              CMD_LAUNCH,
   input  wire logic              CMD_DONE,
   input  wire logic              CMD_VIOLATION,
   input  wire logic              ARRAY_READ,
   input  wire logic              REAL_SINGLE_FAULT,
   input  wire logic              REAL_DOUBLE_FAULT,
   input  wire logic              SINGLE_FLAG_CLR,
   input  wire logic              DOUBLE_FLAG_CLR,
   input  wire logic              SINGLE_IRQ_EN,
   input  wire logic              DOUBLE_IRQ_EN,
   output logic      [IDX_W-1:0]  CMD_WORD_SEL,
   output logic                   BACKDOOR_ENABLED,
   output logic                   MCU_UNSECURED,
   output logic                   CMD_DONE_FLAG,
   output logic                   SINGLE_FAULT_FLAG,
   output logic                   DOUBLE_FAULT_FLAG,
   output logic                   CAPTURE_EN,
   output logic                   CMD_DONE_IRQ,
   output logic                   SINGLE_FAULT_IRQ,
   output logic                   DOUBLE_FAULT_IRQ
);

   logic [7:0]       sec_q;
   logic [7:0]       sec_d;
   logic [IDX_W-1:0] idx_q;
   logic [7:0]       cfg_q;
   logic             done_q;
   logic             done_d;
   logic             sflag_q;
   logic             sflag_d;
   logic             dflag_q;
   logic             dflag_d;
   logic [7:0]       rdata_q;
   logic [7:0]       rdata_d;

   //----------------------------------------------------------------
   // Address decode
   //----------------------------------------------------------------
   wire hit_sec = (ADDR == SEC_STATUS_ADDR);
   wire hit_idx = (ADDR == CMD_IDX_ADDR);
   wire hit_rsv = (ADDR == RSV_TEST_ADDR);
   wire hit_cfg = (ADDR == CFG_CTRL_ADDR);
   wire wr_idx  = WR & hit_idx;
   wire wr_cfg  = WR & hit_cfg;

   //----------------------------------------------------------------
   // Security status
   //----------------------------------------------------------------
   // No bus write path exists for the security register
   always_comb begin
      sec_d = sec_q;
      if (LOAD_VALID) begin
         if (LOAD_DBL_FAULT) begin
            sec_d = SEC_ALL_SET;
         end else begin
            sec_d = LOAD_BYTE;
         end
      end
      if (BACKDOOR_UNLOCK) begin
         sec_d[SECST_HI:SECST_LO] = SEC_UNSECURED;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sec_q <= SEC_RESET;
      end else begin
         sec_q <= sec_d;
      end
   end

   assign BACKDOOR_ENABLED =
      (sec_q[KEY_HI:KEY_LO] == KEY_ENABLED);
   assign MCU_UNSECURED =
      (sec_q[SECST_HI:SECST_LO] == SEC_UNSECURED);

   //----------------------------------------------------------------
   // Command index and configuration
   //----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         idx_q <= IDX_RESET;
      end else if (wr_idx) begin
         idx_q <= WDATA[IDX_W-1:0];
      end
   end

   assign CMD_WORD_SEL = idx_q;

   // Force bits change only by a bus write, so only a zero clears them
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cfg_q <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg_q <= WDATA & CFG_WR_MASK;
      end
   end

   //----------------------------------------------------------------
   // Flags
   //----------------------------------------------------------------
   wire force_sf = cfg_q[CFG_FORCE_SF];
   wire force_df = cfg_q[CFG_FORCE_DF];
   wire ign_sf   = cfg_q[CFG_IGN_SF];
   wire sf_event = ARRAY_READ & (REAL_SINGLE_FAULT | force_sf)
                   & ~ign_sf;
   wire df_event = ARRAY_READ & (REAL_DOUBLE_FAULT | force_df);

   // Set wins over clear on every flag
   always_comb begin
      done_d = done_q;
      if (CMD_LAUNCH) begin
         done_d = 1'b0;
      end
      if (CMD_DONE | CMD_VIOLATION) begin
         done_d = 1'b1;
      end
      sflag_d = sf_event | (sflag_q & ~SINGLE_FLAG_CLR);
      dflag_d = df_event | (dflag_q & ~DOUBLE_FLAG_CLR);
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         done_q  <= 1'b1;
         sflag_q <= 1'b0;
         dflag_q <= 1'b0;
      end else begin
         done_q  <= done_d;
         sflag_q <= sflag_d;
         dflag_q <= dflag_d;
      end
   end

   assign CMD_DONE_FLAG     = done_q;
   assign SINGLE_FAULT_FLAG = sflag_q;
   assign DOUBLE_FAULT_FLAG = dflag_q;

   // Capture only on genuine faults, never on forced ones
   assign CAPTURE_EN = ARRAY_READ & (REAL_DOUBLE_FAULT
                       | (REAL_SINGLE_FAULT & ~ign_sf));

   //----------------------------------------------------------------
   // Interrupt request levels
   //----------------------------------------------------------------
   assign CMD_DONE_IRQ     = done_q & cfg_q[CFG_DONE_IE];
   assign SINGLE_FAULT_IRQ = sflag_q & SINGLE_IRQ_EN;
   assign DOUBLE_FAULT_IRQ = dflag_q & DOUBLE_IRQ_EN;

   //----------------------------------------------------------------
   // Read data
   //----------------------------------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      if (RD) begin
         if (hit_sec) begin
            rdata_d = sec_q;
         end else if (hit_idx) begin
            rdata_d = {{(8-IDX_W){1'b0}}, idx_q};
         end else if (hit_cfg) begin
            rdata_d = cfg_q;
         end else if (hit_rsv) begin
            rdata_d = 8'h00;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign RDATA = rdata_q;

endmodule

// ==== fscr_monitor.sv ====
// Port checker for the flash security config registers
`timescale 1ns/100ps
module fscr_monitor
   import fscr_pkg::*;
(
   input wire logic              CLK,
   input wire logic              RST_N,
   input wire logic              RD,
   input wire logic              LOAD_VALID,
   input wire logic              LOAD_DBL_FAULT,
   input wire logic              BACKDOOR_UNLOCK,
   input wire logic              BACKDOOR_ENABLED,
   input wire logic              MCU_UNSECURED,
   input wire logic              CMD_LAUNCH,
   input wire logic              CMD_DONE,
   input wire logic              CMD_VIOLATION,
   input wire logic              CMD_DONE_FLAG,
   input wire logic              CAPTURE_EN,
   input wire logic              DOUBLE_FAULT_FLAG,
   input wire logic              DOUBLE_IRQ_EN,
   input wire logic              DOUBLE_FAULT_IRQ,
   input wire logic              SINGLE_FAULT_FLAG,
   input wire logic              SINGLE_IRQ_EN,
   input wire logic              SINGLE_FAULT_IRQ,
   input wire logic              ARRAY_READ,
   input wire logic              REAL_SINGLE_FAULT,
   input wire logic              REAL_DOUBLE_FAULT,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [7:0]        RDATA
);
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   wire sec_rd = RD && ADDR == SEC_STATUS_ADDR && !LOAD_VALID
                 && !BACKDOOR_UNLOCK;
   property p_rsv;
      RD && ADDR == RSV_TEST_ADDR |=> RDATA == 8'h00;
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved read not zero");
   property p_cfg; RD && ADDR == CFG_CTRL_ADDR |=> !(RDATA & ~CFG_WR_MASK);
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("config spare bits set");
   property p_key; sec_rd |=> BACKDOOR_ENABLED == (RDATA[7:6] == KEY_ENABLED);
   endproperty
   a_key: assert property (p_key) else $error("key enable wrong");
   property p_sec; sec_rd |=> MCU_UNSECURED == (RDATA[1:0] == SEC_UNSECURED);
   endproperty
   a_sec: assert property (p_sec) else $error("security state wrong");
   property p_unl;
      BACKDOOR_UNLOCK && !LOAD_VALID |=> MCU_UNSECURED;
   endproperty
   a_unl: assert property (p_unl) else $error("unlock not forced");
   property p_dbl; LOAD_VALID && LOAD_DBL_FAULT && !BACKDOOR_UNLOCK
      |=> !BACKDOOR_ENABLED && !MCU_UNSECURED; endproperty
   a_dbl: assert property (p_dbl) else $error("faulty load open");
   property p_lch;
      CMD_LAUNCH && !CMD_DONE && !CMD_VIOLATION |=> !CMD_DONE_FLAG;
   endproperty
   a_lch: assert property (p_lch) else $error("done flag not low");
   property p_dirq; DOUBLE_FAULT_IRQ == (DOUBLE_FAULT_FLAG && DOUBLE_IRQ_EN);
   endproperty
   a_dirq: assert property (p_dirq)
      else $error("double irq wrong");
   property p_sirq; SINGLE_FAULT_IRQ == (SINGLE_FAULT_FLAG && SINGLE_IRQ_EN);
   endproperty
   a_sirq: assert property (p_sirq)
      else $error("single irq wrong");
   property p_cap; CAPTURE_EN |-> ARRAY_READ
      && (REAL_SINGLE_FAULT || REAL_DOUBLE_FAULT); endproperty
   a_cap: assert property (p_cap)
      else $error("capture w/o fault");
   c_unl: cover property (BACKDOOR_UNLOCK ##1 MCU_UNSECURED);
   c_dirq: cover property (DOUBLE_FAULT_IRQ);
   c_cap: cover property (CAPTURE_EN);
endmodule
bind fscr_regs fscr_monitor u_mon (.*);

// ==== tb_top.sv ====
// Self-checking bench for the flash security config registers
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
   $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module tb_top
   import fscr_pkg::*;
();
   localparam int LD = 0, UNL = 1, LCH = 2, DN = 3, VIO = 4, ARD = 5;
   logic CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, LOAD_DBL_FAULT = 1'b0;
   logic REAL_SINGLE_FAULT = 1'b0, REAL_DOUBLE_FAULT = 1'b0;
   logic SINGLE_IRQ_EN = 1'b0, DOUBLE_IRQ_EN = 1'b0;
   logic [7:0] pl = 8'h00, WDATA = 8'h00, LOAD_BYTE = 8'h00, RDATA, rv;
   logic cv;
   logic [ADDR_W-1:0] ADDR = 16'h0000;
   logic [IDX_W-1:0] CMD_WORD_SEL;
   logic BACKDOOR_ENABLED, MCU_UNSECURED, CMD_DONE_FLAG, SINGLE_FAULT_FLAG;
   logic DOUBLE_FAULT_FLAG, CAPTURE_EN, CMD_DONE_IRQ, SINGLE_FAULT_IRQ;
   logic DOUBLE_FAULT_IRQ;
   wire LOAD_VALID, BACKDOOR_UNLOCK, CMD_LAUNCH, CMD_DONE, CMD_VIOLATION;
   wire ARRAY_READ, SINGLE_FLAG_CLR, DOUBLE_FLAG_CLR;
   int error_cnt = 0, n_tests = 0;
   assign {DOUBLE_FLAG_CLR, SINGLE_FLAG_CLR, ARRAY_READ, CMD_VIOLATION,
           CMD_DONE, CMD_LAUNCH, BACKDOOR_UNLOCK, LOAD_VALID} = pl;
   fscr_regs DUT (.*);
   always #12.5 CLK = ~CLK;
   // ---------------------------------------------
   // Bus and pulse tasks
   // ---------------------------------------------
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge CLK);
      {ADDR, WDATA, WR} <= {a, d, 1'b1};
      @(posedge CLK);
      WR <= 1'b0;
      #1;
   endtask
   task rd(input logic [15:0] a);
      @(posedge CLK);
      {ADDR, RD} <= {a, 1'b1};
      @(posedge CLK);
      RD <= 1'b0;
      #1 rv = RDATA;
   endtask
   task pulse(input int i);
      @(posedge CLK);
      pl[i] <= 1'b1;
      #1 cv = CAPTURE_EN;
      @(posedge CLK);
      pl[i] <= 1'b0;
      #1;
   endtask
   task t_regs;
      logic [15:0] a[5];
      logic [7:0] e[5];
      a = '{SEC_STATUS_ADDR, CMD_IDX_ADDR, RSV_TEST_ADDR, CFG_CTRL_ADDR,
            16'h0200};
      e = '{SEC_RESET, 8'hb7 & 8'h07, 8'h00, 8'hb7 & CFG_WR_MASK, 8'h00};
      foreach (a[i]) wr(a[i], 8'hb7);
      `CHK(CMD_WORD_SEL, 3'h7)
      foreach (a[i]) begin
         rd(a[i]);
         `CHK(rv, e[i])
      end
   endtask
   task t_sec;
      for (int k = 0; k < 4; k++) begin
         LOAD_BYTE <= {k[1:0], 4'hf, k[1:0]};
         pulse(LD);
         `CHK(BACKDOOR_ENABLED, k == 2)
         `CHK(MCU_UNSECURED, k == 2)
         rd(SEC_STATUS_ADDR);
         `CHK(rv, {k[1:0], 4'hf, k[1:0]})
      end
      {LOAD_DBL_FAULT, LOAD_BYTE} <= {1'b1, 8'hbe};
      pulse(LD);
      LOAD_DBL_FAULT <= 1'b0;
      rd(SEC_STATUS_ADDR);
      `CHK(rv, SEC_ALL_SET)
      pulse(UNL);
      rd(SEC_STATUS_ADDR);
      `CHK(rv, {6'h3f, SEC_UNSECURED})
   endtask
   task t_flt;
      {SINGLE_IRQ_EN, DOUBLE_IRQ_EN} <= 2'h3;
      wr(CFG_CTRL_ADDR, 8'h03);
      pulse(ARD);
      `CHK({SINGLE_FAULT_IRQ, DOUBLE_FAULT_IRQ}, 2'h3)
      `CHK(cv, 1'b0)
      pl[7:6] <= 2'h3;
      wr(CFG_CTRL_ADDR, 8'h13);
      pl[7:6] <= 2'h0;
      pulse(ARD);
      `CHK({SINGLE_FAULT_FLAG, DOUBLE_FAULT_FLAG}, 2'h1)
      rd(CFG_CTRL_ADDR);
      `CHK(rv, 8'h13)
      pl[7:6] <= 2'h3;
      wr(CFG_CTRL_ADDR, 8'h00);
      pl[7:6] <= 2'h0;
      pulse(ARD);
      `CHK({SINGLE_FAULT_FLAG, DOUBLE_FAULT_FLAG}, 2'h0)
      {REAL_SINGLE_FAULT, REAL_DOUBLE_FAULT} <= 2'h3;
      pulse(ARD);
      {REAL_SINGLE_FAULT, REAL_DOUBLE_FAULT} <= 2'h0;
      `CHK(cv, 1'b1)
      `CHK({SINGLE_FAULT_FLAG, DOUBLE_FAULT_FLAG}, 2'h3)
   endtask
   task t_done;
      wr(CFG_CTRL_ADDR, 8'h80);
      pulse(LCH);
      `CHK({CMD_DONE_FLAG, CMD_DONE_IRQ}, 2'h0)
      pulse(DN);
      `CHK({CMD_DONE_FLAG, CMD_DONE_IRQ}, 2'h3)
      pulse(LCH);
      pulse(VIO);
      wr(CFG_CTRL_ADDR, 8'h00);
      `CHK({CMD_DONE_FLAG, CMD_DONE_IRQ}, 2'h2)
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge CLK);
      RST_N <= 1'b1;
      t_regs;
      t_sec;
      t_flt;
      t_done;
      stop_test;
   end
   initial begin
      repeat (4000) @(posedge CLK);
      error_cnt++;
      stop_test;
   end
endmodule
